// ---- src/rxdv_pkg.sv ----
// constants and types for the receive data-valid control block
package rxdv_pkg;
	// clock and sequencer timing
	localparam int CLK_MHZ = 20;
	localparam int DETECT_TIME_US = 2600;
	localparam int DETECT_CYC = DETECT_TIME_US * CLK_MHZ;
	localparam int PATH_TIME_US = 2200;
	localparam int PATH_CYC = PATH_TIME_US * CLK_MHZ;
	localparam int ACT_W = 17;
	// register indices; byte address is four times the index
	localparam logic [3:0] IDX_CFG = 4'h0;
	localparam logic [3:0] IDX_ON = 4'h4;
	localparam logic [3:0] IDX_OFF = 4'h5;
	localparam logic [3:0] IDX_LOW = 4'h6;
	localparam logic [3:0] IDX_UP = 4'h7;
	localparam logic [3:0] IDX_LVL = 4'h8;
	localparam logic [3:0] IDX_STAT = 4'h9;
	localparam int ADDR_W = 8;
	// reset values
	localparam logic [15:0] CFG_RST = 16'h0000;
	localparam logic [15:0] ON_RST = 16'hFEBF;
	localparam logic [15:0] OFF_RST = 16'hF37F;
	localparam logic [11:0] LOW_RST = 12'h000;
	localparam logic [11:0] UP_RST = 12'h001;
	localparam logic [5:0] LVL_RST = 6'h3F;
	// field positions
	localparam int CFG_SLICER_BIT = 15;
	localparam int CFG_CONT_BIT = 5;
	localparam int CFG_SINGLE_BIT = 6;
	localparam int STAT_VALID = 0;
	localparam int STAT_POLL = 1;
	localparam int STAT_DETECT = 2;
	localparam int STAT_PKD = 3;
	localparam int STAT_DONE = 4;
	// detection constants
	localparam logic [1:0] DIV_LAST = 2'h3;
	localparam logic [1:0] PERIOD_LAST = 2'h2;
	localparam logic [12:0] HI_MAX = 13'h1FFF;
	localparam logic [5:0] LVL_OFF = 6'h3F;
	localparam logic [15:0] POLL_MAX = 16'hFFFF;
	typedef enum logic [1:0] {DS_OFF, DS_MEAS, DS_STOP} det_t;
	typedef enum logic {PH_ON, PH_OFF} phase_t;
endpackage

// ---- src/rx_data_valid_detect.sv ----
// receive control: slicer select, peak detector power, data-valid detection
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
module rx_data_valid_detect #(
	parameter int DETECT_DELAY_CYC = rxdv_pkg::DETECT_CYC,
	parameter int PATH_DELAY_CYC = rxdv_pkg::PATH_CYC
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [rxdv_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// receive path inputs
	input wire logic rx_active,
	input wire logic data_in,
	input wire logic [5:0] rssi_code,
	input wire logic rc_tick,
	// analog control outputs
	output logic slicer_peak_sel,
	output logic pkd_enable,
	output logic pkd_pos_force_low,
	output logic pkd_neg_force_high,
	// detection and polling outputs
	output logic detect_enable,
	output logic data_valid,
	output logic window_done,
	output logic poll_on_phase
);
	import rxdv_pkg::*;

	logic [15:0] cfg_ff;
	logic [15:0] on_ff;
	logic [15:0] off_ff;
	logic [11:0] low_ff;
	logic [11:0] up_ff;
	logic [5:0] lvl_ff;
	logic [31:0] prdata_ff;
	logic err_ff;
	logic [ACT_W-1:0] act_cnt_ff;
	logic detect_ff;
	logic pkd_ff;
	det_t det_ff;
	logic [1:0] div_ff;
	logic [12:0] hi_cnt_ff;
	logic data_d_ff;
	logic [1:0] period_ff;
	logic rate_all_ff;
	logic done_ff;
	logic level_ok_ff;
	logic valid_ff;
	phase_t phase_ff;
	logic [15:0] poll_cnt_ff;
	logic [3:0] idx;
	logic mapped;
	logic setup_ph;
	logic wr_acc;
	logic fall;
	logic rise;
	logic win_active;
	logic lvl_active;
	logic lvl_hit;
	logic single_hit;
	logic double_hit;
	logic win_hit;
	logic last_period;
	logic single_mode;
	logic [12:0] low2;
	logic [12:0] up2;
	logic [31:0] nxt_rdata;
	logic poll_last;

	// address decode: word aligned, index in bits 5:2
	assign idx = paddr[5:2];
	assign setup_ph = psel && !penable;
	assign wr_acc = psel && penable && pwrite && mapped;
	always_comb begin
		if (paddr[1:0] != 2'h0 || paddr[ADDR_W-1:6] != '0) begin
			mapped = 1'b0;
		end else if (idx == IDX_CFG || idx == IDX_ON || idx == IDX_OFF) begin
			mapped = 1'b1;
		end else if (idx == IDX_LOW || idx == IDX_UP || idx == IDX_LVL) begin
			mapped = 1'b1;
		end else if (idx == IDX_STAT) begin
			mapped = 1'b1;
		end else begin
			mapped = 1'b0;
		end
	end

	// read mux, narrow registers in low bits
	always_comb begin
		nxt_rdata = 32'h0000_0000;
		if (idx == IDX_CFG) begin
			nxt_rdata[15:0] = cfg_ff;
		end else if (idx == IDX_ON) begin
			nxt_rdata[15:0] = on_ff;
		end else if (idx == IDX_OFF) begin
			nxt_rdata[15:0] = off_ff;
		end else if (idx == IDX_LOW) begin
			nxt_rdata[11:0] = low_ff;
		end else if (idx == IDX_UP) begin
			nxt_rdata[11:0] = up_ff;
		end else if (idx == IDX_LVL) begin
			nxt_rdata[5:0] = lvl_ff;
		end else if (idx == IDX_STAT) begin
			nxt_rdata[STAT_VALID] = valid_ff;
			nxt_rdata[STAT_POLL] = (phase_ff == PH_ON);
			nxt_rdata[STAT_DETECT] = detect_ff;
			nxt_rdata[STAT_PKD] = pkd_ff;
			nxt_rdata[STAT_DONE] = level_ok_ff;
		end
		if (!mapped) begin
			nxt_rdata = 32'h0000_0000;
		end
	end

	// read data and error captured in the setup cycle, zero wait access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_ff <= 32'h0000_0000;
			err_ff <= 1'b0;
		end else if (setup_ph) begin
			prdata_ff <= nxt_rdata;
			err_ff <= !mapped;
		end
	end
	assign prdata = prdata_ff;
	assign pready = 1'b1;
	assign pslverr = psel && penable && err_ff;

	// register writes; status is read only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_ff <= CFG_RST;
			on_ff <= ON_RST;
			off_ff <= OFF_RST;
			low_ff <= LOW_RST;
			up_ff <= UP_RST;
			lvl_ff <= LVL_RST;
		end else if (wr_acc) begin
			if (idx == IDX_CFG) begin
				cfg_ff <= pwdata[15:0];
			end else if (idx == IDX_ON) begin
				on_ff <= pwdata[15:0];
			end else if (idx == IDX_OFF) begin
				off_ff <= pwdata[15:0];
			end else if (idx == IDX_LOW) begin
				low_ff <= pwdata[11:0];
			end else if (idx == IDX_UP) begin
				up_ff <= pwdata[11:0];
			end else if (idx == IDX_LVL) begin
				lvl_ff <= pwdata[5:0];
			end
		end
	end

	// slicer source select; peak detectors do not depend on it
	assign slicer_peak_sel = cfg_ff[CFG_SLICER_BIT];
	assign single_mode = cfg_ff[CFG_SINGLE_BIT] && !cfg_ff[CFG_CONT_BIT];

	// time since receiver activation, saturating
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			act_cnt_ff <= '0;
		end else if (!rx_active) begin
			act_cnt_ff <= '0;
		end else if (act_cnt_ff < ACT_W'(DETECT_DELAY_CYC)) begin
			act_cnt_ff <= act_cnt_ff + 1'b1;
		end
	end

	// sequencer enables: peak detectors and detection
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pkd_ff <= 1'b0;
			detect_ff <= 1'b0;
		end else begin
			pkd_ff <= rx_active && act_cnt_ff >= ACT_W'(PATH_DELAY_CYC);
			detect_ff <= rx_active && act_cnt_ff >= ACT_W'(DETECT_DELAY_CYC);
		end
	end
	assign pkd_enable = pkd_ff;
	assign pkd_pos_force_low = !pkd_ff;
	assign pkd_neg_force_high = !pkd_ff;
	assign detect_enable = detect_ff;

	// rate window and level compares
	assign win_active = !(low_ff == LOW_RST && up_ff == UP_RST);
	assign lvl_active = lvl_ff != LVL_OFF;
	assign low2 = {low_ff, 1'b0};
	assign up2 = {up_ff, 1'b0};
	assign single_hit = hi_cnt_ff >= {1'b0, low_ff} && hi_cnt_ff <= {1'b0, up_ff};
	assign double_hit = hi_cnt_ff >= low2 && hi_cnt_ff <= up2;
	assign win_hit = win_active && (single_hit || double_hit);
	assign lvl_hit = lvl_active && rssi_code > lvl_ff;
	assign fall = data_d_ff && !data_in;
	assign rise = !data_d_ff && data_in;
	assign last_period = period_ff == PERIOD_LAST;

	// detection state: off, measuring, stopped after a single shot
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			det_ff <= DS_OFF;
		end else if (!detect_ff) begin
			det_ff <= DS_OFF;
		end else begin
			case (det_ff)
				DS_OFF: begin
					det_ff <= DS_MEAS;
				end
				DS_MEAS: begin
					if (fall && last_period && single_mode) begin
						det_ff <= DS_STOP;
					end
				end
				default: begin
					det_ff <= DS_STOP;
				end
			endcase
		end
	end

	// divide by four and high time counter
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_ff <= 2'h0;
			hi_cnt_ff <= 13'h0000;
			data_d_ff <= 1'b0;
		end else begin
			data_d_ff <= data_in;
			div_ff <= div_ff + 1'b1;
			if (det_ff != DS_MEAS || rise) begin
				hi_cnt_ff <= 13'h0000;
				div_ff <= 2'h0;
			end else if (data_in && div_ff == DIV_LAST && hi_cnt_ff != HI_MAX) begin
				hi_cnt_ff <= hi_cnt_ff + 1'b1;
			end
		end
	end

	// three measured periods form one decision
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			period_ff <= 2'h0;
			rate_all_ff <= 1'b1;
		end else if (det_ff != DS_MEAS) begin
			period_ff <= 2'h0;
			rate_all_ff <= 1'b1;
		end else if (fall) begin
			if (last_period) begin
				period_ff <= 2'h0;
				rate_all_ff <= 1'b1;
			end else begin
				period_ff <= period_ff + 1'b1;
				rate_all_ff <= rate_all_ff && win_hit;
			end
		end
	end

	// window done pulse latches level and forms data valid
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			done_ff <= 1'b0;
			level_ok_ff <= 1'b0;
			valid_ff <= 1'b0;
		end else begin
			done_ff <= det_ff == DS_MEAS && fall && last_period;
			if (!detect_ff) begin
				level_ok_ff <= 1'b0;
				valid_ff <= 1'b0;
			end else if (det_ff == DS_MEAS && fall && last_period) begin
				level_ok_ff <= lvl_hit;
				valid_ff <= lvl_hit && rate_all_ff && win_hit;
			end
		end
	end
	assign window_done = done_ff;
	assign data_valid = valid_ff;

	// last tick of a phase; swapping here gives 65535 minus load ticks
	assign poll_last = poll_cnt_ff >= POLL_MAX - 16'h0001;

	// self polling timer on the rc oscillator tick
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase_ff <= PH_ON;
			poll_cnt_ff <= ON_RST;
		end else if (rc_tick) begin
			if (poll_last) begin
				case (phase_ff)
					PH_ON: begin
						phase_ff <= PH_OFF;
						poll_cnt_ff <= off_ff;
					end
					default: begin
						phase_ff <= PH_ON;
						poll_cnt_ff <= on_ff;
					end
				endcase
			end else begin
				poll_cnt_ff <= poll_cnt_ff + 1'b1;
			end
		end
	end
	assign poll_on_phase = phase_ff == PH_ON;

	// checks
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	chk_pkd_off_ties: assert property (
		!pkd_enable |-> pkd_pos_force_low && pkd_neg_force_high)
		else $error("peak outputs not parked while off");
	chk_pkd_after_path: assert property (
		$rose(pkd_enable) |-> $past(rx_active)
			&& $past(act_cnt_ff) >= ACT_W'(PATH_DELAY_CYC))
		else $error("peak detector enabled before path active");
	chk_pkd_slicer_free: assert property (
		$changed(slicer_peak_sel) && pkd_enable |=> pkd_enable || !$past(rx_active))
		else $error("peak detector followed slicer select");
	chk_detect_delay: assert property (
		$rose(detect_enable) |-> $past(act_cnt_ff) == ACT_W'(DETECT_DELAY_CYC))
		else $error("detection enabled at wrong time");
	chk_detect_drop: assert property (
		!rx_active |=> !detect_enable ##1 !data_valid)
		else $error("detection stayed on after rx off");
	chk_valid_moment: assert property (
		$rose(data_valid) |-> $past(det_ff == DS_MEAS && fall && last_period)
			&& window_done)
		else $error("data valid rose outside window done");
	chk_valid_level: assert property (
		$rose(data_valid) |-> $past(rssi_code > lvl_ff) && level_ok_ff)
		else $error("data valid without level");
	chk_window_idle: assert property (
		low_ff == LOW_RST && up_ff == UP_RST |-> !win_hit)
		else $error("default window matched");
	chk_level_idle: assert property (
		lvl_ff == LVL_OFF |-> !lvl_hit)
		else $error("all ones level matched");
	chk_single_stop: assert property (
		window_done && single_mode && detect_enable |-> det_ff == DS_STOP)
		else $error("single shot kept measuring");
	chk_three_periods: assert property (
		fall && det_ff == DS_MEAS && last_period |=> period_ff == 2'h0
			&& window_done)
		else $error("decision not after three periods");
	chk_high_ticks: assert property (
		det_ff == DS_MEAS && data_in && !rise && hi_cnt_ff == 13'h0000
			##1 data_in [*4] |-> hi_cnt_ff == 13'h0001)
		else $error("high time not counted in quarter ticks");
	chk_poll_swap: assert property (
		rc_tick && poll_last && phase_ff == PH_ON
			|=> phase_ff == PH_OFF && poll_cnt_ff == off_ff)
		else $error("poll phase did not swap");
	chk_slicer_reset: assert property (
		$rose(presetn) |-> !slicer_peak_sel)
		else $error("slicer bit not zero after reset");
	chk_apb_unmapped: assert property (
		setup_ph && !mapped ##1 penable |-> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");

	cov_valid: cover property (window_done && data_valid);
	cov_invalid: cover property (window_done && !data_valid);
	cov_single: cover property (det_ff == DS_STOP);
	cov_poll_off: cover property (!poll_on_phase);
endmodule

// ---- bench/rx_source.sv ----
// far-side model: demodulated data pulses and rc oscillator ticks
`timescale 1ns/1ps
module rx_source (
	// clock
	input wire logic pclk,
	// receive path outputs
	output logic data_in,
	output logic rc_tick
);
	logic tick_ff = 1'b0;
	// rc oscillator runs free at half the bus clock
	always_ff @(posedge pclk) begin
		tick_ff <= ~tick_ff;
	end
	assign rc_tick = tick_ff;
	// data idles low between bursts
	initial begin
		data_in = 1'b0;
	end
	// three high pulses make one decision span, gaps of 16 cycles
	task automatic burst(input int hi);
		for (int i = 0; i < 3; i++) begin
			data_in <= 1'b1;
			repeat (hi) @(posedge pclk);
			data_in <= 1'b0;
			if (i < 2) begin
				repeat (16) @(posedge pclk);
			end
		end
	endtask
endmodule

// ---- bench/rx_data_valid_detect_bench.sv ----
// self-checking bench for the receive data-valid control block
`timescale 1ns/1ps
module rx_data_valid_detect_bench;
	import rxdv_pkg::*;
	localparam int DET = 20;
	localparam int PATH = 10;
	logic pclk, presetn, psel, penable, pwrite, rx_active;
	logic [ADDR_W-1:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic pready, pslverr, err, data_in, rc_tick;
	logic [5:0] rssi_code;
	logic slicer_peak_sel, pkd_enable, pkd_pos_force_low;
	logic pkd_neg_force_high, detect_enable, data_valid;
	logic window_done, poll_on_phase;
	int n_mismatch = 0;
	int compares = 0;
	// register indices and reset values
	logic [3:0] ri [6] = '{IDX_CFG, IDX_ON, IDX_OFF, IDX_LOW, IDX_UP, IDX_LVL};
	logic [31:0] rv [6] = '{32'h0, 32'hFEBF, 32'hF37F, 32'h0, 32'h1, 32'h3F};
	// detection cases: window, level, strength, high cycles, outcome
	int c_lo [7] = '{0, 3, 3, 3, 3, 3, 3};
	int c_up [7] = '{1, 5, 5, 5, 5, 5, 5};
	int c_lv [7] = '{10, 10, 63, 10, 10, 10, 10};
	int c_rs [7] = '{20, 20, 63, 10, 20, 20, 20};
	int c_hi [7] = '{4, 16, 16, 16, 32, 48, 13};
	logic c_ok [7] = '{0, 1, 0, 0, 1, 0, 1};

	rx_data_valid_detect #(.DETECT_DELAY_CYC(DET), .PATH_DELAY_CYC(PATH))
		rx_data_valid_detect_inst (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rx_active(rx_active), .data_in(data_in),
		.rssi_code(rssi_code), .rc_tick(rc_tick),
		.slicer_peak_sel(slicer_peak_sel), .pkd_enable(pkd_enable),
		.pkd_pos_force_low(pkd_pos_force_low),
		.pkd_neg_force_high(pkd_neg_force_high),
		.detect_enable(detect_enable), .data_valid(data_valid),
		.window_done(window_done), .poll_on_phase(poll_on_phase));
	rx_source rx_source_inst (.pclk(pclk), .data_in(data_in),
		.rc_tick(rc_tick));

	// clock source
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end

	task automatic report_and_stop();
		if (n_mismatch == 0 && compares > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// one apb transfer; read data and error taken at the access edge
	task automatic apb(input logic wr, input logic [3:0] idx,
		input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {2'h0, idx, 2'h0};
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rdc(input logic [3:0] idx, input logic [31:0] exp);
		apb(1'b0, idx, 32'h0);
		chk(rd, exp);
	endtask

	// send one decision span and check the verdict after window done
	task automatic decide(input int hi, input logic ok);
		int n;
		n = 0;
		rx_source_inst.burst(hi);
		while (window_done !== 1'b1 && n < 8) begin
			@(posedge pclk);
			n++;
		end
		chk({31'h0, window_done}, 32'h1);
		chk({31'h0, data_valid}, {31'h0, ok});
	endtask

	// cycles spent in one polling phase
	task automatic span(input logic lvl, output int n);
		int w;
		w = 0;
		n = 0;
		while (poll_on_phase !== lvl && w < 2000) begin
			@(posedge pclk);
			w++;
		end
		while (poll_on_phase === lvl && n < 2000) begin
			@(posedge pclk);
			n++;
		end
	endtask

	// main sequence
	initial begin
		int n;
		logic seen;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = 32'h0;
		rx_active = 1'b0;
		rssi_code = 6'h0;
		seen = 1'b0;
		repeat (12) @(posedge pclk);
		chk({24'h0, slicer_peak_sel, pkd_enable, pkd_pos_force_low,
			pkd_neg_force_high, poll_on_phase, detect_enable,
			data_valid, window_done}, 32'h38);
		presetn <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			rdc(ri[i], rv[i]);
		end
		chk({31'h0, err}, 32'h0);
		apb(1'b0, 4'hB, 32'h0);
		chk({31'h0, err}, 32'h1);
		chk(rd, 32'h0);
		apb(1'b1, IDX_ON, 32'hFFFF_FFF8);
		apb(1'b1, IDX_OFF, 32'hFFFF_FFF0);
		rdc(IDX_ON, 32'hFFF8);
		apb(1'b1, IDX_LOW, 32'hFFFF_FFFF);
		rdc(IDX_LOW, 32'hFFF);
		apb(1'b1, IDX_LVL, 32'hFFFF_FFFF);
		rdc(IDX_LVL, 32'h3F);
		span(1'b0, n);
		// off phase: 15 rc ticks, two clock cycles each
		chk(32'(n), 32'h1E);
		span(1'b1, n);
		// on phase: 7 rc ticks, two clock cycles each
		chk(32'(n), 32'h0E);
		rx_active <= 1'b1;
		n = 0;
		while (pkd_enable !== 1'b1 && n < 200) begin
			@(posedge pclk);
			n++;
		end
		chk(32'(n >= PATH && n <= PATH + 4), 32'h1);
		chk({30'h0, pkd_pos_force_low, pkd_neg_force_high}, 32'h0);
		chk({31'h0, detect_enable}, 32'h0);
		while (detect_enable !== 1'b1 && n < 200) begin
			@(posedge pclk);
			n++;
		end
		chk(32'(n >= DET && n <= DET + 4), 32'h1);
		apb(1'b1, IDX_CFG, 32'h8020);
		// let the config word written at the access edge settle
		@(posedge pclk);
		chk({30'h0, slicer_peak_sel, pkd_enable}, 32'h3);
		for (int i = 0; i < 7; i++) begin
			apb(1'b1, IDX_LOW, 32'(c_lo[i]));
			apb(1'b1, IDX_UP, 32'(c_up[i]));
			apb(1'b1, IDX_LVL, 32'(c_lv[i]));
			rssi_code <= 6'(c_rs[i]);
			decide(c_hi[i], c_ok[i]);
		end
		apb(1'b1, IDX_CFG, 32'h0040);
		@(posedge pclk);
		chk({31'h0, slicer_peak_sel}, 32'h0);
		decide(16, 1'b1);
		rx_source_inst.burst(16);
		repeat (8) begin
			@(posedge pclk);
			if (window_done === 1'b1) begin
				seen = 1'b1;
			end
		end
		chk({31'h0, seen}, 32'h0);
		rx_active <= 1'b0;
		repeat (4) @(posedge pclk);
		chk({27'h0, pkd_enable, pkd_pos_force_low, pkd_neg_force_high,
			detect_enable, data_valid}, 32'hC);
		report_and_stop();
	end

	// watchdog cuts a hang short
	initial begin
		repeat (6000) @(posedge pclk);
		n_mismatch++;
		report_and_stop();
	end
endmodule
